// [deac_top.v]
// Purpose: AXI4-Lite register front end of the data EEPROM access controller.
// Assumes: aresetn is a general reset; por_n marks power-up and also resets.
// Notes: Program memory space is selectable but has no backing store here.
`timescale 1ns/10ps
`include "deac_map.vh"
module deac_top #(
  parameter PWRUP_CYCLES = `DEAC_PWRUP_MS * 1000 * 1000 / (1000 / `DEAC_CLK_MHZ),
  parameter WRITE_CYCLES = `DEAC_WRITE_US * `DEAC_CLK_MHZ
)
(
  input wire aclk,
  input wire aresetn,
  input wire por_n,
  input wire data_protect_fuse,
  input wire programmer_req,
  output wire programmer_grant,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  localparam UL_IDLE = 2'h0;
  localparam UL_FIRST = 2'h1;
  localparam UL_ARMED = 2'h2;

  reg [7:0] address_low;
  reg [7:0] address_high;
  reg [7:0] data_low;
  reg [7:0] data_high;
  reg program_space_select;
  reg config_space_select;
  reg write_permit;
  reg write_abort_flag;
  reg write_done_flag;
  reg read_strobe;
  reg [1:0] unlock_state;
  reg [31:0] pwrup_count;
  reg aw_held;
  reg w_held;
  reg [11:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg last_reset_in_write;
  wire arr_busy;
  wire arr_done;
  wire [7:0] arr_rd_data;
  wire pwrup_running;
  wire do_write;
  wire do_read;
  wire [7:0] wbyte;
  wire ctl_wr;
  wire wr_strobe_req;
  wire unlock_ok;
  wire write_start;
  wire sel_control;
  wire sel_unlock;
  wire sel_addr_low;
  wire sel_addr_high;
  wire sel_data_low;
  wire sel_data_high;
  wire sel_flags;
  wire wr_addr_bad;
  wire rd_data_space;
  reg [31:0] next_rdata;
  reg [1:0] next_rresp;

  ////////////////////////////////////////////////////////////////////////////////

  function [31:0] deac_ctl_word;
    input pgm;
    input cfg;
    input abort;
    input permit;
    input wr;
    input rd;
    begin
      deac_ctl_word = 32'h0;
      deac_ctl_word[`DEAC_BIT_PGMSEL] = pgm;
      deac_ctl_word[`DEAC_BIT_CFGSEL] = cfg;
      deac_ctl_word[`DEAC_BIT_ABORT] = abort;
      deac_ctl_word[`DEAC_BIT_PERMIT] = permit;
      deac_ctl_word[`DEAC_BIT_WR] = wr;
      deac_ctl_word[`DEAC_BIT_RD] = rd;
    end
  endfunction

  // A register is hit only through byte lane 0, since each register holds one byte.
  function deac_lane0_hit;
    input [11:0] addr;
    input [11:0] offset;
    input [3:0] strb;
    begin
      deac_lane0_hit = (addr == offset) && strb[0];
    end
  endfunction

  deac_array #(
    .DEPTH(256),
    .AW(8),
    .WRITE_CYCLES(WRITE_CYCLES)
  ) u_array (
    .aclk(aclk),
    .por_n(por_n),
    .rd_addr(address_low),
    .rd_data(arr_rd_data),
    .wr_start(write_start),
    .wr_addr(address_low),
    .wr_data(data_low),
    .wr_busy(arr_busy),
    .wr_done(arr_done)
  );

  // The programmer port is refused while the data memory is protected.
  assign programmer_grant = programmer_req && data_protect_fuse;

  ////////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data are taken in either order, then one response.

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wbyte = w_data[7:0];
  assign sel_control = do_write && deac_lane0_hit(aw_addr, `DEAC_OFF_CONTROL, w_strb);
  assign sel_unlock = do_write && deac_lane0_hit(aw_addr, `DEAC_OFF_UNLOCK, w_strb);
  assign sel_addr_low = do_write && deac_lane0_hit(aw_addr, `DEAC_OFF_ADDR_LOW, w_strb);
  assign sel_addr_high = do_write && deac_lane0_hit(aw_addr, `DEAC_OFF_ADDR_HIGH, w_strb);
  assign sel_data_low = do_write && deac_lane0_hit(aw_addr, `DEAC_OFF_DATA_LOW, w_strb);
  assign sel_data_high = do_write && deac_lane0_hit(aw_addr, `DEAC_OFF_DATA_HIGH, w_strb);
  assign sel_flags = do_write && deac_lane0_hit(aw_addr, `DEAC_OFF_FLAGS, w_strb);
  assign wr_addr_bad = (aw_addr[11:2] > (`DEAC_OFF_FLAGS >> 2)) || (aw_addr[1:0] != 2'h0);
  // Reads land in the data register only while the data space is selected.
  assign rd_data_space = !program_space_select && !config_space_select;
  assign ctl_wr = sel_control;
  assign wr_strobe_req = ctl_wr && wbyte[`DEAC_BIT_WR];
  assign unlock_ok = (unlock_state == UL_ARMED);
  assign pwrup_running = (pwrup_count != 32'h0);
  assign write_start = wr_strobe_req && unlock_ok && write_permit && !arr_busy
    && !pwrup_running && !program_space_select;

  always @(posedge aclk)
  begin
    if (!por_n)
      pwrup_count <= PWRUP_CYCLES;
    else if (pwrup_running)
      pwrup_count <= pwrup_count - 32'h1;
  end

  always @(posedge aclk)
  begin
    if (!aresetn || !por_n)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DEAC_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (wr_addr_bad)
          s_axi_bresp <= `DEAC_RESP_SLVERR;
        else
          s_axi_bresp <= `DEAC_RESP_OKAY;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Unlock sequencer; any access except the expected one drops the arming.

  always @(posedge aclk)
  begin
    if (!aresetn || !por_n)
      unlock_state <= UL_IDLE;
    else if (do_write || (s_axi_arvalid && s_axi_arready))
    begin
      case (unlock_state)
        UL_IDLE:
          if (sel_unlock && wbyte == `DEAC_UNLOCK_FIRST)
            unlock_state <= UL_FIRST;
        UL_FIRST:
          if (sel_unlock && wbyte == `DEAC_UNLOCK_SECOND)
            unlock_state <= UL_ARMED;
          else
            unlock_state <= UL_IDLE;
        default:
          unlock_state <= UL_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control and holding registers.

  always @(posedge aclk)
  begin
    if (!por_n)
    begin
      write_permit <= 1'b0;
      write_abort_flag <= 1'b0;
      last_reset_in_write <= 1'b0;
    end
    else
    begin
      last_reset_in_write <= !aresetn && arr_busy;
      if (last_reset_in_write)
        write_abort_flag <= 1'b1;
      else if (ctl_wr && !wbyte[`DEAC_BIT_ABORT])
        write_abort_flag <= 1'b0;
      if (aresetn && ctl_wr)
        write_permit <= wbyte[`DEAC_BIT_PERMIT];
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn || !por_n)
    begin
      program_space_select <= 1'b0;
      config_space_select <= 1'b0;
      address_low <= 8'h00;
      address_high <= 8'h00;
      data_high <= 8'h00;
      read_strobe <= 1'b0;
    end
    else
    begin
      read_strobe <= 1'b0;
      if (ctl_wr)
      begin
        program_space_select <= wbyte[`DEAC_BIT_PGMSEL];
        config_space_select <= wbyte[`DEAC_BIT_CFGSEL];
        read_strobe <= wbyte[`DEAC_BIT_RD];
      end
      if (sel_addr_low)
        address_low <= wbyte;
      if (sel_addr_high)
        address_high <= wbyte & `DEAC_ADDR_HIGH_MASK;
      if (sel_data_high)
        data_high <= wbyte & `DEAC_DATA_HIGH_MASK;
    end
  end

  // The data register survives a reset so a read value is kept for software.
  always @(posedge aclk)
  begin
    if (!por_n)
      data_low <= 8'h00;
    else if (read_strobe && rd_data_space)
      data_low <= arr_rd_data;
    else if (aresetn && sel_data_low)
      data_low <= wbyte;
  end

  // A completion in the same cycle as a software clear keeps the flag set.
  always @(posedge aclk)
  begin
    if (!aresetn || !por_n)
      write_done_flag <= 1'b0;
    else if (arr_done)
      write_done_flag <= 1'b1;
    else if (sel_flags && w_data[`DEAC_BIT_DONE])
      write_done_flag <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read channel.

  assign s_axi_arready = !s_axi_rvalid;
  assign do_read = s_axi_arvalid && s_axi_arready;

  always @*
  begin
    next_rdata = 32'h0;
    next_rresp = `DEAC_RESP_OKAY;
    if (s_axi_araddr[1:0] != 2'h0)
      next_rresp = `DEAC_RESP_SLVERR;
    else if (s_axi_araddr == `DEAC_OFF_CONTROL)
      next_rdata = deac_ctl_word(program_space_select, config_space_select,
        write_abort_flag, write_permit, arr_busy, read_strobe);
    else if (s_axi_araddr == `DEAC_OFF_UNLOCK)
      next_rdata = 32'h0;
    else if (s_axi_araddr == `DEAC_OFF_ADDR_LOW)
      next_rdata = {24'h0, address_low};
    else if (s_axi_araddr == `DEAC_OFF_ADDR_HIGH)
      next_rdata = {24'h0, address_high};
    else if (s_axi_araddr == `DEAC_OFF_DATA_LOW)
      next_rdata = {24'h0, data_low};
    else if (s_axi_araddr == `DEAC_OFF_DATA_HIGH)
      next_rdata = {24'h0, data_high};
    else if (s_axi_araddr == `DEAC_OFF_FLAGS)
      next_rdata = {31'h0, write_done_flag};
    else
      next_rresp = `DEAC_RESP_SLVERR;
  end

  always @(posedge aclk)
  begin
    if (!aresetn || !por_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `DEAC_RESP_OKAY;
    end
    else if (do_read)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule

// [deac_map.vh]
// Purpose: Register map, field positions and timing constants of the data EEPROM access block.
// Assumes: AXI4-Lite with 32-bit data, one aligned word per register.
// Notes: Offsets are byte addresses.
// Behaviour
// - Address pair reaches 256 data bytes or 32K program words.
// - Data EEPROM accesses use only the low address register.
// - Space select clear picks data EEPROM, set picks program memory; resets clear.
// - Read and write strobes set by software only, cleared by hardware at completion.
// - Write permit clears at power-up only; hardware never clears it later.
// - Reset during a write sets the write abort flag for software to see.
// - Write completion clears the write strobe and sets the sticky done flag.
// - Unlock register reads back as all zeros.
// - Write starts only after 55h, AAh to unlock, then write strobe.
// - Write strobe cannot be set while write permit is clear.
// - Clearing write permit during a running write does not stop it.
// - Data read places the addressed byte in the low data register next cycle.
// - Low data register holds a read value until next read or software write.
// - Writes are suppressed during the 64 ms power-up timer.
// - Data protect fuse at 0 denies programmer access, CPU access remains.
// - CPU reads succeed whatever the data protect fuse setting.
// - Byte write erases the location before programming new data.
// - Write duration comes from an internal timer.
`ifndef DEAC_MAP_VH
`define DEAC_MAP_VH
`define DEAC_OFF_CONTROL 12'h000
`define DEAC_OFF_UNLOCK 12'h004
`define DEAC_OFF_ADDR_LOW 12'h008
`define DEAC_OFF_ADDR_HIGH 12'h00C
`define DEAC_OFF_DATA_LOW 12'h010
`define DEAC_OFF_DATA_HIGH 12'h014
`define DEAC_OFF_FLAGS 12'h018
`define DEAC_BIT_RD 0
`define DEAC_BIT_WR 1
`define DEAC_BIT_PERMIT 2
`define DEAC_BIT_ABORT 3
`define DEAC_BIT_CFGSEL 6
`define DEAC_BIT_PGMSEL 7
`define DEAC_BIT_DONE 0
`define DEAC_UNLOCK_FIRST 8'h55
`define DEAC_UNLOCK_SECOND 8'hAA
`define DEAC_ADDR_HIGH_MASK 8'h7F
`define DEAC_DATA_HIGH_MASK 8'h3F
`define DEAC_PWRUP_MS 64
`define DEAC_CLK_MHZ 100
`define DEAC_WRITE_US 4
`define DEAC_RESP_OKAY 2'h0
`define DEAC_RESP_SLVERR 2'h2
`endif

// [deac_array.v]
// Purpose: Data EEPROM byte array with timed erase-then-program writes.
// Assumes: One write at a time; reads are combinational from flip-flops.
// Notes: The array is held in flip-flops; all of it is erased to FFh at power-up, and one byte at each write start.
`timescale 1ns/10ps
`include "deac_map.vh"
module deac_array #(
  parameter DEPTH = 256,
  parameter AW = 8,
  parameter WRITE_CYCLES = 400
)
(
  input wire aclk,
  input wire por_n,
  input wire [AW-1:0] rd_addr,
  output wire [7:0] rd_data,
  input wire wr_start,
  input wire [AW-1:0] wr_addr,
  input wire [7:0] wr_data,
  output reg wr_busy,
  output reg wr_done
);
  reg [7:0] mem [0:DEPTH-1];
  reg [31:0] timer;
  reg [AW-1:0] hold_addr;
  reg [7:0] hold_data;
  integer i;

  assign rd_data = mem[rd_addr];

  always @(posedge aclk)
  begin
    wr_done <= 1'b0;
    if (!por_n)
    begin
      wr_busy <= 1'b0;
      timer <= 32'h0;
      hold_addr <= {AW{1'b0}};
      hold_data <= 8'h00;
      for (i = 0; i < DEPTH; i = i + 1)
        mem[i] <= 8'hFF;
    end
    else if (wr_start && !wr_busy)
    begin
      wr_busy <= 1'b1;
      timer <= WRITE_CYCLES - 1;
      hold_addr <= wr_addr;
      hold_data <= wr_data;
      mem[wr_addr] <= 8'hFF;
    end
    else if (wr_busy)
    begin
      if (timer == 32'h0)
      begin
        wr_busy <= 1'b0;
        wr_done <= 1'b1;
        mem[hold_addr] <= hold_data;
      end
      else
        timer <= timer - 32'h1;
    end
  end
endmodule

// [deac_properties.sv]
// Purpose: Port-level properties of the data EEPROM access block.
// Assumes: Bound to deac_top; one clock domain.
// Notes: ra keeps the address of the read in flight.
`timescale 1ns/10ps
module deac_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic por_n,
  input wire logic data_protect_fuse,
  input wire logic programmer_req,
  input wire logic programmer_grant,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [11:0] ra;
  always @(posedge aclk)
  begin
    if (s_axi_arvalid && s_axi_arready)
    begin
      ra <= s_axi_araddr;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !por_n);
  ////////////////////////////////////////////////////////////////
  a_grant_fuse: assert property (programmer_grant == (programmer_req & data_protect_fuse))
    else $error("grant mismatch");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bvalid dropped");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rvalid dropped");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready during rvalid");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("awready during bvalid");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid)
    else $error("write answer late");
  a_unlock_zero: assert property (s_axi_rvalid && ra == 12'h004 |-> s_axi_rdata == 32'h0)
    else $error("unlock read not zero");
  a_bad_addr: assert property (s_axi_rvalid && ra > 12'h018 |-> s_axi_rresp == 2'h2)
    else $error("unmapped read not refused");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  c_unlock: cover property (s_axi_rvalid && ra == 12'h004);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_grant: cover property (programmer_grant);
endmodule

// [tb.sv]
// Purpose: Self-checking bench for the data EEPROM access block.
// Assumes: Short power-up and write timers set by parameters.
// Notes: Registers are reached only through AXI4-Lite tasks.
`timescale 1ns/10ps
module tb;
  localparam int PWRUP = 80;
  localparam int WCYC = 20;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic por_n = 1'b0;
  logic fuse = 1'b1;
  logic preq = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  wire grant, awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  logic [31:0] rv;
  logic [1:0] resp;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  deac_top #(.PWRUP_CYCLES(PWRUP), .WRITE_CYCLES(WCYC)) dut (
    .aclk(aclk), .aresetn(aresetn), .por_n(por_n), .data_protect_fuse(fuse),
    .programmer_req(preq), .programmer_grant(grant),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );
  initial
  begin
    forever #5 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
    begin
      $display("*** PASS ***");
    end
    else
    begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      fails++;
      conclude();
    end
  end
  task automatic chk(input string nm, input [31:0] s, input [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Response ready stands with the request and drops at the edge that sees the answer.
  task automatic wr(input [11:0] a, input [7:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
    resp = bresp;
  endtask
  task automatic rd(input [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    rready <= 1'b0;
    rv = rdata;
    resp = rresp;
  endtask
  task automatic rc(input string nm, input [11:0] a, input [7:0] e);
    rd(a);
    chk(nm, rv, {24'h000000, e});
  endtask
  task automatic seq(input [7:0] c);
    wr(12'h004, 8'h55);
    wr(12'h004, 8'hAA);
    wr(12'h000, c);
  endtask
  task automatic eread(input string nm, input [7:0] adr, input [7:0] e);
    wr(12'h008, adr);
    wr(12'h000, 8'h01);
    rc(nm, 12'h010, e);
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    por_n <= 1'b1;
    rc("ctl reset", 12'h000, 8'h00);
    wr(12'h008, 8'h10);
    wr(12'h010, 8'h5A);
    wr(12'h000, 8'h04);
    seq(8'h06);
    rc("ctl pwrup", 12'h000, 8'h04);
    repeat (WCYC) @(posedge aclk);
    eread("arr pwrup", 8'h10, 8'hFF);
    repeat (PWRUP) @(posedge aclk);
    wr(12'h000, 8'h80);
    rc("pgm sel", 12'h000, 8'h80);
    wr(12'h004, 8'h55);
    rc("unlock", 12'h004, 8'h00);
    wr(12'h000, 8'h00);
    seq(8'h02);
    rc("no permit", 12'h000, 8'h00);
    rc("no done", 12'h018, 8'h00);
    wr(12'h010, 8'h5A);
    wr(12'h000, 8'h04);
    seq(8'h06);
    rc("busy", 12'h000, 8'h06);
    wr(12'h000, 8'h00);
    rc("permit off", 12'h000, 8'h02);
    rd(12'h018);
    while (rv[0] !== 1'b1) rd(12'h018);
    rc("idle", 12'h000, 8'h00);
    rc("done stick", 12'h018, 8'h01);
    wr(12'h018, 8'h01);
    rc("done clr", 12'h018, 8'h00);
    fuse <= 1'b0;
    preq <= 1'b1;
    wr(12'h010, 8'h00);
    wr(12'h00C, 8'hFF);
    rc("addr high", 12'h00C, 8'h7F);
    eread("readback", 8'h10, 8'h5A);
    chk("grant off", grant, 0);
    wr(12'h008, 8'h20);
    rc("hold", 12'h010, 8'h5A);
    wr(12'h000, 8'h41);
    rc("cfg read", 12'h010, 8'h5A);
    wr(12'h000, 8'h04);
    wr(12'h004, 8'h55);
    rd(12'h000);
    wr(12'h004, 8'hAA);
    wr(12'h000, 8'h06);
    rc("gap", 12'h000, 8'h04);
    wr(12'h004, 8'hAA);
    wr(12'h004, 8'h55);
    wr(12'h000, 8'h06);
    rc("order", 12'h000, 8'h04);
    seq(8'h06);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (WCYC) @(posedge aclk);
    rc("abort", 12'h000, 8'h0C);
    wr(12'h000, 8'h00);
    rc("abort clr", 12'h000, 8'h00);
    wr(12'h01C, 8'h01);
    chk("bresp", resp, 2);
    rd(12'h01C);
    chk("rresp", resp, 2);
    fuse <= 1'b1;
    @(posedge aclk);
    chk("grant on", grant, 1);
    conclude();
  end
endmodule
bind deac_top deac_properties props (
  .aclk(aclk), .aresetn(aresetn), .por_n(por_n), .data_protect_fuse(data_protect_fuse),
  .programmer_req(programmer_req), .programmer_grant(programmer_grant),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready)
);
